// *** shared/adcss_pkg.sv ***
// Package: constants and carrier types for the single-channel converter sequencer
// Notes on behaviour
// [R1] One-shot mode converts the chosen input once per start, then stops.
// [R2] Software trigger: writing start to 1 begins conversion at once.
// [R3] External trigger: falling pin edge after start set begins; later edges retrigger.
// [R4] One-shot completion halts and requests interrupt; software trigger also clears start.
// [R5] Software clearing start halts any conversion in either mode.
// [R6] Repeat mode converts back to back, no interrupt, stops only on start cleared.
// [R7] Input is a primary input, an alternate group input or an extension input.
// [R8] Result lands in the result register matching the selected input.
// [R9] Software must not rewrite control register 0 during conversion.
// [R10] Software must not rewrite control register 1 during conversion.
// [R11] After changing mode, software rewrites channel select in a later access.
// [R12] After reference connect goes high, software waits 1 us before starting.
// [R13] Alternate groups behave like primary inputs, group select picks the group.
// [R14] Without sample-and-hold: 49 clocks at 8 bits, 59 at 10 bits.
// [R15] With sample-and-hold: 28 clocks at 8 bits, 33 at 10 bits.
// [R16] Repeat mode overwrites the same result register after each conversion.
// [R17] External trigger selected, start set, no edge yet: stay idle and armed.
package adcss_pkg;

    localparam int RES_W = 10;
    localparam int NUM_RESULTS = 8;
    localparam logic [5:0] CYC_8BIT_NOSH = 6'h31;
    localparam logic [5:0] CYC_10BIT_NOSH = 6'h3B;
    localparam logic [5:0] CYC_8BIT_SH = 6'h1C;
    localparam logic [5:0] CYC_10BIT_SH = 6'h21;
    // System clocks per conversion clock
    localparam logic [2:0] CONV_DIV = 3'h2;
    localparam logic [1:0] MODE_ONE_SHOT = 2'h0;
    localparam logic [1:0] MODE_REPEAT = 2'h1;
    localparam logic [1:0] AMP_NONE = 2'h0;
    localparam logic [1:0] AMP_EXT0 = 2'h1;
    localparam logic [1:0] AMP_EXT1 = 2'h2;
    localparam logic [2:0] EXT0_RESULT_IDX = 3'h0;
    localparam logic [2:0] EXT1_RESULT_IDX = 3'h1;
    localparam logic TRIG_SOFTWARE = 1'b0;
    localparam logic TRIG_EXTERNAL = 1'b1;

    typedef enum {ST_IDLE, ST_ARMED, ST_CONVERT} adcss_state_type;

    // Control bits that software sets
    typedef struct packed {
        logic [1:0] mode_select;
        logic trigger_source_select;
        logic [2:0] channel_select;
        logic [1:0] port_group_select;
        logic [1:0] external_amp_select;
        logic res_10bit;
        logic sample_hold;
    } adcss_ctrl_type;

    // Input routing to the analog front end
    typedef struct packed {
        logic [1:0] port_group_select;
        logic [2:0] channel_select;
        logic [1:0] external_amp_select;
        logic sampling;
    } adcss_route_type;

    typedef logic [NUM_RESULTS-1:0][RES_W-1:0] adcss_results_type;

endpackage : adcss_pkg

// *** hdl/adcss_sequencer.sv ***
// Single-channel one-shot and repeat conversion sequencer
`timescale 1ns/1ns
module adcss_sequencer (
    input wire logic SYS_CLK_I,
    input wire logic SYS_RST_I,
    input wire adcss_pkg::adcss_ctrl_type CTRL_I,
    input wire logic START_WR_I,
    input wire logic START_DATA_I,
    input wire logic EXT_TRIG_PIN_I,
    input wire logic [adcss_pkg::RES_W-1:0] ANALOG_CODE_I,
    output logic CONV_START_O,
    output logic BUSY_O,
    output logic IRQ_O,
    output adcss_pkg::adcss_route_type ROUTE_O,
    output adcss_pkg::adcss_results_type RESULT_O
);
    import adcss_pkg::*;

    typedef struct packed {
        adcss_state_type state;
        logic start;
        logic trig_s0;
        logic trig_s1;
        logic trig_prev;
        logic [RES_W-1:0] code_s0;
        logic [RES_W-1:0] code_s1;
        logic [2:0] div_cnt;
        logic [5:0] conv_cnt;
        logic irq;
        logic [6:0] run_cnt;
        adcss_route_type route;
        adcss_results_type results;
    } adcss_regs_type;

    adcss_regs_type r_q;
    adcss_regs_type r_d;

    // Conversion length in conversion clocks
    function automatic logic [5:0] conv_len(input logic res10, input logic sh);
        if (sh) begin
            conv_len = res10 ? CYC_10BIT_SH : CYC_8BIT_SH; // R15
        end else begin
            conv_len = res10 ? CYC_10BIT_NOSH : CYC_8BIT_NOSH; // R14
        end
    endfunction : conv_len

    // Result slot for the selected input
    function automatic logic [2:0] result_idx(input adcss_ctrl_type c);
        if (c.external_amp_select == AMP_EXT0) begin
            result_idx = EXT0_RESULT_IDX; // R7
        end else if (c.external_amp_select == AMP_EXT1) begin
            result_idx = EXT1_RESULT_IDX; // R7
        end else begin
            result_idx = c.channel_select; // R8 R13
        end
    endfunction : result_idx

    logic trig_fall;
    logic tick;
    logic last_tick;
    logic [2:0] slot_idx;
    logic [6:0] span_exp;
    assign trig_fall = r_q.trig_prev & ~r_q.trig_s1;
    assign tick = (r_q.div_cnt == CONV_DIV - 3'd1);
    assign last_tick = tick && (r_q.conv_cnt == conv_len(CTRL_I.res_10bit,
        CTRL_I.sample_hold) - 6'd1);
    // Result slot of the selected input, shared by the write and its check
    assign slot_idx = result_idx(CTRL_I);
    // Expected busy span in system cycles, from the package counts alone
    assign span_exp = 7'(CONV_DIV) * 7'(CTRL_I.sample_hold
        ? (CTRL_I.res_10bit ? CYC_10BIT_SH : CYC_8BIT_SH)
        : (CTRL_I.res_10bit ? CYC_10BIT_NOSH : CYC_8BIT_NOSH));

    // Next-state logic
    always_comb begin
        r_d = r_q;
        r_d.irq = 1'b0;
        r_d.trig_s0 = EXT_TRIG_PIN_I;
        r_d.trig_s1 = r_q.trig_s0;
        r_d.trig_prev = r_q.trig_s1;
        r_d.code_s0 = ANALOG_CODE_I;
        r_d.code_s1 = r_q.code_s0;
        r_d.div_cnt = tick ? 3'd0 : r_q.div_cnt + 3'd1;
        r_d.route.port_group_select = CTRL_I.port_group_select; // R13
        r_d.route.channel_select = CTRL_I.channel_select; // R7
        r_d.route.external_amp_select = CTRL_I.external_amp_select; // R7
        case (r_q.state)
            ST_IDLE, ST_ARMED: begin
                r_d.state = (r_q.start && CTRL_I.trigger_source_select == TRIG_EXTERNAL)
                    ? ST_ARMED : ST_IDLE; // R17
                if (r_q.start && CTRL_I.trigger_source_select == TRIG_EXTERNAL
                        && trig_fall) begin
                    r_d.state = ST_CONVERT; // R3
                    r_d.conv_cnt = 6'd0;
                    r_d.div_cnt = 3'd0;
                end
            end
            ST_CONVERT: begin
                if (tick) begin
                    r_d.conv_cnt = r_q.conv_cnt + 6'd1;
                end
                if (CTRL_I.trigger_source_select == TRIG_EXTERNAL && trig_fall) begin
                    r_d.conv_cnt = 6'd0; // R3
                    r_d.div_cnt = 3'd0;
                end else if (last_tick) begin
                    r_d.results[slot_idx] = r_q.code_s1; // R8 R16
                    r_d.conv_cnt = 6'd0;
                    if (CTRL_I.mode_select == MODE_REPEAT) begin
                        r_d.state = ST_CONVERT; // R6
                    end else begin
                        r_d.irq = 1'b1; // R1 R4
                        if (CTRL_I.trigger_source_select == TRIG_SOFTWARE) begin
                            r_d.start = 1'b0; // R4
                            r_d.state = ST_IDLE;
                        end else begin
                            r_d.state = ST_ARMED; // R3
                        end
                    end
                end
            end
            default: begin
                r_d.state = ST_IDLE;
            end
        endcase
        // Software write to start bit overrides hardware clear
        if (START_WR_I) begin
            r_d.start = START_DATA_I;
            if (!START_DATA_I) begin
                r_d.state = ST_IDLE; // R5
                r_d.conv_cnt = 6'd0;
            end else if (CTRL_I.trigger_source_select == TRIG_SOFTWARE
                    && r_q.state != ST_CONVERT) begin
                r_d.state = ST_CONVERT; // R2
                r_d.conv_cnt = 6'd0;
                r_d.div_cnt = 3'd0;
            end
        end
        r_d.route.sampling = (r_d.state == ST_CONVERT);
        // Busy-cycle count for the span check, cleared when a retrigger restarts
        if (r_q.state == ST_CONVERT
                && !(CTRL_I.trigger_source_select == TRIG_EXTERNAL && trig_fall)) begin
            r_d.run_cnt = r_q.run_cnt + 7'h01;
        end else begin
            r_d.run_cnt = 7'h00;
        end
    end

    // State register
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            r_q <= '0;
            r_q.state <= ST_IDLE;
            r_q.trig_s0 <= 1'b1;
            r_q.trig_s1 <= 1'b1;
            r_q.trig_prev <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    // Outputs from registers
    assign CONV_START_O = r_q.start;
    assign BUSY_O = (r_q.state == ST_CONVERT);
    assign IRQ_O = r_q.irq;
    assign ROUTE_O = r_q.route;
    assign RESULT_O = r_q.results;

    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (SYS_RST_I);

    a_sw_start_begins: assert property ( // R2
        START_WR_I && START_DATA_I && CTRL_I.trigger_source_select == TRIG_SOFTWARE
        && !BUSY_O |=> BUSY_O)
        else $error("software start did not begin conversion");
    a_ext_armed_idle: assert property ( // R17
        r_q.state == ST_ARMED && !trig_fall && !START_WR_I |=> !BUSY_O)
        else $error("armed converter started without edge");
    a_ext_edge_start: assert property ( // R3
        r_q.state == ST_ARMED && trig_fall && !START_WR_I
        && CTRL_I.trigger_source_select == TRIG_EXTERNAL |=> BUSY_O && r_q.conv_cnt == 6'd0)
        else $error("falling edge did not start conversion");
    a_stop_halts: assert property ( // R5
        START_WR_I && !START_DATA_I |=> !BUSY_O && !CONV_START_O)
        else $error("clearing start did not halt");
    a_oneshot_done: assert property ( // R4
        BUSY_O && last_tick && !trig_fall && !START_WR_I
        && CTRL_I.mode_select == MODE_ONE_SHOT
        && CTRL_I.trigger_source_select == TRIG_SOFTWARE
        |=> IRQ_O && !BUSY_O && !CONV_START_O)
        else $error("one-shot completion wrong");
    a_repeat_no_irq: assert property ( // R6
        BUSY_O && CTRL_I.mode_select == MODE_REPEAT && !START_WR_I |=> !IRQ_O && BUSY_O)
        else $error("repeat mode stopped or raised request");
    a_result_written: assert property ( // R8
        BUSY_O && last_tick && !trig_fall && !START_WR_I
        |=> RESULT_O[$past(slot_idx)] == $past(r_q.code_s1))
        else $error("result not stored in selected slot");
    a_len_8bit_sh: assert property ( // R15
        BUSY_O && CTRL_I.res_10bit == 1'b0 && CTRL_I.sample_hold
        && tick && r_q.conv_cnt == CYC_8BIT_SH - 6'h01 |-> last_tick)
        else $error("sample-hold 8-bit length wrong");
    a_len_10bit: assert property ( // R14
        BUSY_O && CTRL_I.res_10bit && !CTRL_I.sample_hold
        && tick && r_q.conv_cnt == CYC_10BIT_NOSH - 6'h02 |-> !last_tick)
        else $error("10-bit conversion ended early");
    a_conv_span: assert property ( // R14 R15
        IRQ_O |-> r_q.run_cnt == span_exp)
        else $error("conversion span differs from its length");
    a_ext_rearm: assert property ( // R3
        BUSY_O && last_tick && !trig_fall && !START_WR_I
        && CTRL_I.mode_select != MODE_REPEAT
        && CTRL_I.trigger_source_select == TRIG_EXTERNAL
        |=> IRQ_O && !BUSY_O && CONV_START_O)
        else $error("external one-shot did not re-arm");

    c_oneshot: cover property (IRQ_O);
    c_repeat: cover property (BUSY_O && last_tick && CTRL_I.mode_select == MODE_REPEAT);
    c_retrigger: cover property (BUSY_O && trig_fall
        && CTRL_I.trigger_source_select == TRIG_EXTERNAL);
    c_stop: cover property (BUSY_O && START_WR_I && !START_DATA_I);
    c_rearm: cover property (IRQ_O && CONV_START_O);

endmodule : adcss_sequencer

// *** bench/tb_top.sv ***
// Self-checking bench for the single-channel conversion sequencer
`timescale 1ns/1ns
module tb_top;
    import adcss_pkg::*;
    typedef struct packed {
        adcss_ctrl_type ctrl;
        logic [9:0] code;
        logic [7:0] cyc;
        logic [2:0] slot;
    } adcss_tb_row_type;
    logic sys_clk, sys_rst, start_wr, start_data, trig_pin, conv_start, busy, irq;
    logic [RES_W-1:0] code;
    adcss_ctrl_type ctrl;
    adcss_route_type route;
    adcss_results_type results;
    int failures = 0, num_checks = 0, nb, ni;
    adcss_tb_row_type rows [6];
    adcss_sequencer dut (.SYS_CLK_I(sys_clk), .SYS_RST_I(sys_rst), .CTRL_I(ctrl),
        .START_WR_I(start_wr), .START_DATA_I(start_data), .EXT_TRIG_PIN_I(trig_pin),
        .ANALOG_CODE_I(code), .CONV_START_O(conv_start), .BUSY_O(busy), .IRQ_O(irq),
        .ROUTE_O(route), .RESULT_O(results));
    // Clock of 100 ns period
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // Compare and report
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task close_out();
        $display("Checks %0d, mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out
    // One start bit write, one cycle strobe
    task sw_write(input logic d);
        @(negedge sys_clk);
        start_wr = 1'b1;
        start_data = d;
        @(negedge sys_clk);
        start_wr = 1'b0;
    endtask : sw_write
    // Count busy cycles and interrupt pulses over a window
    task watch(input int len);
        nb = 0;
        ni = 0;
        repeat (len) begin
            @(negedge sys_clk);
            if (busy === 1'b1) nb++;
            if (irq === 1'b1) ni++;
        end
    endtask : watch
    // Watchdog
    initial begin
        #(8000 * 100);
        failures++;
        close_out();
    end
    initial begin
        ctrl = '0;
        {start_wr, start_data, sys_rst} = 3'h1;
        trig_pin = 1'b1;
        code = 10'h000;
        // 8 bit / 10 bit, hold off / on, every group, every amp code
        rows[0] = '{'{2'h0, 1'b0, 3'h3, 2'h0, 2'h0, 1'b0, 1'b0}, 10'h0A5, 8'd98, 3'h3};
        rows[1] = '{'{2'h0, 1'b0, 3'h7, 2'h1, 2'h0, 1'b1, 1'b0}, 10'h3C7, 8'd118, 3'h7};
        rows[2] = '{'{2'h0, 1'b0, 3'h4, 2'h2, 2'h0, 1'b0, 1'b1}, 10'h155, 8'd56, 3'h4};
        rows[3] = '{'{2'h0, 1'b0, 3'h5, 2'h0, 2'h1, 1'b1, 1'b1}, 10'h2AA, 8'd66, 3'h0};
        rows[4] = '{'{2'h2, 1'b0, 3'h6, 2'h0, 2'h2, 1'b0, 1'b1}, 10'h0F0, 8'd56, 3'h1};
        rows[5] = '{'{2'h0, 1'b0, 3'h2, 2'h3, 2'h3, 1'b0, 1'b1}, 10'h30F, 8'd56, 3'h2};
        repeat (5) @(negedge sys_clk);
        sys_rst = 1'b0;
        chk({conv_start, busy, irq, route}, 32'h0);
        for (int s = 0; s < NUM_RESULTS; s++) chk(results[s], 32'h0);
        $display("Test reset done");
        // Reference settling time of 1 us before the first start
        repeat (10) @(negedge sys_clk);
        foreach (rows[i]) begin
            ctrl = rows[i].ctrl;
            code = rows[i].code;
            sw_write(1'b1);
            chk(busy, 1);
            chk(route, {ctrl.port_group_select, ctrl.channel_select,
                ctrl.external_amp_select, 1'b1});
            watch(140);
            chk(nb, rows[i].cyc - 1);
            chk(route.sampling, 0);
            chk(ni, 1);
            chk(conv_start, 0);
            chk(results[rows[i].slot], rows[i].code);
            $display("Test row %0d done", i);
        end
        // External trigger: armed, then falling edges start and retrigger
        ctrl = rows[2].ctrl;
        ctrl.trigger_source_select = TRIG_EXTERNAL;
        trig_pin = 1'b0;
        repeat (3) @(negedge sys_clk);
        trig_pin = 1'b1;
        sw_write(1'b1);
        watch(20);
        chk(nb, 0);
        trig_pin = 1'b0;
        watch(20);
        // Two sync stages pass before busy shows
        chk(nb, 18);
        trig_pin = 1'b1;
        repeat (4) @(negedge sys_clk);
        trig_pin = 1'b0;
        watch(100);
        // Two cycles of the first run, then one full run after the retrigger
        chk(nb, 2 * CYC_8BIT_SH + 2);
        chk(ni, 1);
        chk(conv_start, 1);
        chk(busy, 0);
        $display("Test external trigger done");
        // Stop by clearing the start bit mid conversion
        ctrl.trigger_source_select = TRIG_SOFTWARE;
        sw_write(1'b1);
        repeat (10) @(negedge sys_clk);
        chk(busy, 1);
        sw_write(1'b0);
        watch(140);
        chk(nb, 0);
        chk(ni, 0);
        chk(conv_start, 0);
        $display("Test stop done");
        // Start rewritten while busy must not restart; 13 busy cycles precede the window
        sw_write(1'b1);
        repeat (10) @(negedge sys_clk);
        sw_write(1'b1);
        watch(140);
        chk(nb, 2 * CYC_8BIT_SH - 13);
        chk(ni, 1);
        $display("Test busy rewrite done");
        // Repeat mode: back to back, no interrupt, newest value kept
        ctrl.mode_select = MODE_REPEAT;
        @(negedge sys_clk);
        ctrl.channel_select = rows[2].ctrl.channel_select;
        code = 10'h111;
        sw_write(1'b1);
        watch(140);
        code = 10'h222;
        watch(140);
        chk(nb == 140 && ni == 0, 1);
        chk(results[4], 10'h222);
        sw_write(1'b0);
        watch(20);
        chk(nb, 0);
        chk(ni, 0);
        $display("Test repeat done");
        // Reset in mid conversion clears state, outputs and every result
        sw_write(1'b1);
        repeat (10) @(negedge sys_clk);
        sys_rst = 1'b1;
        repeat (5) @(negedge sys_clk);
        sys_rst = 1'b0;
        chk({conv_start, busy, irq, route}, 32'h0);
        for (int s = 0; s < NUM_RESULTS; s++) chk(results[s], 32'h0);
        repeat (2) @(negedge sys_clk);
        chk({conv_start, busy, irq}, 32'h0);
        $display("Test mid reset done");
        close_out();
    end
endmodule : tb_top
